// ---- verilog/flash_cmd_pkg.sv ----
// constants, types and helper function for the erase and power-down sequencer
// assumes a 50 MHz system clock and an SPI host working in mode 0 or 3
//
// Functional notes
// RULE1: sector wipe sets whole 64-Kbyte sector to FFh, needs write-unlock flag set.
// RULE2: sector wipe is opcode plus three address bytes; A23 and A22 ignored.
// RULE3: sector wipe runs only if select rises after exactly 32 bits.
// RULE4: valid sector wipe starts timed erase, busy flag high, unlock flag cleared.
// RULE5: sector wipe inside the protect-level area is not executed.
// RULE6: array wipe is opcode only, sets whole array to FFh, needs unlock flag.
// RULE7: array wipe runs only if select rises after exactly 8 bits.
// RULE8: valid array wipe runs timed erase, busy flag high, unlock flag cleared.
// RULE9: array wipe runs only when all three protect-level bits are zero.
// RULE10: deselected and idle means standby; deep sleep only by sleep opcode.
// RULE11: sleep opcode is one byte; any other bit count is not executed.
// RULE12: after valid sleep opcode, deep sleep entered once entry delay elapses.
// RULE13: in deep sleep every instruction except wake is ignored.
// RULE14: sleep or wake during a running erase is rejected, erase unaffected.
// RULE15: wake opcode with extra clocks before select rises is rejected.
// RULE16: after valid wake, standby returns once wake delay elapses.
// RULE17: power loss clears deep sleep; device always starts in standby.
// RULE18: host keeps device deselected 30 us after supply and at power-down; the bench host first selects it 130 ns after time zero.
// RULE19: while power-on reset is active logic is held, nothing answered.
// RULE20: during write-inhibit window all write-type instructions are ignored.
// RULE21: host reads after select delay, writes after both delays; the bench host sends its first write inside the inhibit window.
// RULE22: after power-up: standby, unlock flag clear, busy flag clear, locks (0,0).
// RULE23: all instruction byte values are design parameters.
package flash_cmd_pkg;

	// ********************************************************
	// timing
	// ********************************************************
	localparam longint CLK_HZ = 50_000_000;
	localparam longint US_PER_S = 1_000_000;
	localparam longint MS_PER_S = 1_000;
	localparam int CNT_W = 32;
	localparam longint SLEEP_ENTRY_US = 3;
	localparam longint WAKE_US = 30;
	localparam longint INHIBIT_MS = 10;
	localparam longint BLOCK64_WIPE_MS = 1;
	localparam longint ARRAY_WIPE_MS = 10;
	// least waits round up, the inhibit window (longest, tied with array wipe) rounds down
	localparam longint SLEEP_ENTRY_CYC = (SLEEP_ENTRY_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
	localparam longint WAKE_CYC = (WAKE_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
	localparam longint INHIBIT_CYC = (INHIBIT_MS * CLK_HZ) / MS_PER_S;
	localparam longint BLOCK64_WIPE_CYC = (BLOCK64_WIPE_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
	localparam longint ARRAY_WIPE_CYC = (ARRAY_WIPE_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;

	// ********************************************************
	// frame layout and defaults
	// ********************************************************
	localparam logic [5:0] OPCODE_BITS = 6'h08;
	localparam logic [5:0] ADDR_CMD_BITS = 6'h20;
	localparam logic [5:0] BIT_CNT_CAP = 6'h28;
	localparam int SECTOR_LSB = 16;
	localparam int SECTOR_MSB = 21;
	localparam logic [6:0] NUM_SECTORS = 7'h40;
	localparam logic [2:0] PROTECT_NONE = 3'h0;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// arbitrary opcode defaults, real encodings come in as top parameters
	localparam logic [7:0] DEF_UNLOCK_OP = 8'h11;
	localparam logic [7:0] DEF_BLOCK64_OP = 8'h22;
	localparam logic [7:0] DEF_ARRAY_OP = 8'h33;
	localparam logic [7:0] DEF_SLEEP_OP = 8'h44;
	localparam logic [7:0] DEF_WAKE_OP = 8'h55;

	// ********************************************************
	// types
	// ********************************************************
	typedef enum logic [1:0] {PWR_STANDBY, PWR_SLEEP_ENTRY, PWR_DEEP, PWR_WAKE} power_state_t;
	typedef enum logic [1:0] {WIPE_NONE, WIPE_BLOCK64, WIPE_ARRAY} wipe_kind_t;
	typedef struct packed {
		wipe_kind_t kind;
		logic [5:0] sector;
		logic [7:0] fill;
	} wipe_req_t;
	typedef struct packed {
		logic [7:0] op_short;
		logic [7:0] op_long;
		logic [23:0] addr;
	} frame_t;

	// top 2^(level-1) sectors are protected, level 7 covers all
	function automatic logic sector_protected(input logic [2:0] level, input logic [5:0] sector);
		logic [6:0] first;
		first = NUM_SECTORS - (7'h01 << (level - 3'h1));
		if (level == PROTECT_NONE)
			sector_protected = 1'b0;
		else
			sector_protected = ({1'b0, sector} >= first);
	endfunction

endpackage

// ---- verilog/pin_sync.sv ----
// two-flop synchroniser for pins arriving from the spi host
// assumes inputs asynchronous to sys_clk_i; only the second flop is read outside
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	// clock and control
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// pins
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] pin_sync_o
);
	logic [WIDTH-1:0] meta;

	// ********************************************************
	// synchroniser stages
	// ********************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			meta <= '1;
			pin_sync_o <= '1;
		end
		else if (clk_en_i)
		begin
			meta <= pin_i;
			pin_sync_o <= meta;
		end
	end
endmodule // pin_sync

// ---- verilog/cycle_timer.sv ----
// down counter for self-timed cycles and power delays
// assumes load_i is a one-cycle pulse; count_i of zero gives no busy time
`timescale 1ns/10ps
module cycle_timer #(
	parameter int CNT_W = 32
) (
	// clock and control
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// request
	input wire logic load_i,
	input wire logic [CNT_W-1:0] count_i,
	// state
	output logic busy_o,
	output logic done_o
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;

	// reload wins, otherwise count down to zero
	assign next_cnt = load_i ? count_i : ((cnt != '0) ? cnt - 1'b1 : '0);

	// ********************************************************
	// counter
	// ********************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			cnt <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			cnt <= next_cnt;
			busy_o <= (next_cnt != '0);
			done_o <= (cnt == {{(CNT_W-1){1'b0}}, 1'b1}) && !load_i;
		end
	end
endmodule // cycle_timer

// ---- verilog/serial_flash_erase_power_control.sv ----
// command handling for sector wipe, array wipe, deep sleep and wake of a serial flash
// assumes rst_i is the internal power-on reset and spi pins are asynchronous
`timescale 1ns/10ps
module serial_flash_erase_power_control
	import flash_cmd_pkg::*;
#(
	parameter logic [7:0] UNLOCK_OP = DEF_UNLOCK_OP, // see RULE23
	parameter logic [7:0] BLOCK64_OP = DEF_BLOCK64_OP,
	parameter logic [7:0] ARRAY_OP = DEF_ARRAY_OP,
	parameter logic [7:0] SLEEP_OP = DEF_SLEEP_OP,
	parameter logic [7:0] WAKE_OP = DEF_WAKE_OP,
	parameter logic [CNT_W-1:0] INHIBIT_CYCLES = CNT_W'(INHIBIT_CYC),
	parameter logic [CNT_W-1:0] BLOCK64_WIPE_CYCLES = CNT_W'(BLOCK64_WIPE_CYC),
	parameter logic [CNT_W-1:0] ARRAY_WIPE_CYCLES = CNT_W'(ARRAY_WIPE_CYC)
) (
	// clock, power-on reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// spi pins from the host
	input wire logic select_n_i,
	input wire logic sclk_i,
	input wire logic serial_in_line_i,
	// configuration
	input wire logic [2:0] protect_level_bits_i,
	// status
	output logic write_unlock_flag_o,
	output logic cycle_active_flag_o,
	output logic standby_o,
	output logic deep_power_down_o,
	output logic write_inhibit_o,
	// erase request to the array
	output logic wipe_start_o,
	output wipe_req_t wipe_req_o,
	// frame discarded on select rise
	output logic cmd_discard_o
);

	// ********************************************************
	// parameter checks
	// ********************************************************
	if (BLOCK64_WIPE_CYCLES == '0 || ARRAY_WIPE_CYCLES == '0)
		$error("erase cycle counts must be at least one");
	if (SLEEP_ENTRY_CYC < 1 || WAKE_CYC < 1)
		$error("power delay counts must be at least one");
	if (UNLOCK_OP == BLOCK64_OP || UNLOCK_OP == ARRAY_OP || BLOCK64_OP == ARRAY_OP)
		$error("write opcodes must be distinct");
	if (SLEEP_OP == WAKE_OP || SLEEP_OP == ARRAY_OP || WAKE_OP == ARRAY_OP)
		$error("power opcodes must be distinct");

	// ********************************************************
	// declarations
	// ********************************************************
	logic [2:0] pins_s;
	logic sel_s;
	logic sclk_s;
	logic din_s;
	logic sclk_d;
	logic sel_d;
	logic sclk_rise;
	logic sel_rise;
	logic sel_fall;
	logic [31:0] shift;
	logic [31:0] next_shift;
	logic [5:0] bit_cnt;
	logic [5:0] next_bit_cnt;
	frame_t frame;
	logic one_byte;
	logic four_byte;
	logic [5:0] sector;
	logic [CNT_W-1:0] inhibit_cnt;
	logic inhibit;
	logic write_unlock_flag;
	logic next_wel;
	logic erase_busy;
	logic erase_done;
	power_state_t pwr;
	power_state_t next_pwr;
	logic pwr_busy;
	logic pwr_done;
	logic writes_ok;
	logic do_unlock;
	logic do_block;
	logic do_array;
	logic do_sleep;
	logic do_wake;
	logic wipe_go;
	logic known_op;
	logic valid_any;
	logic [CNT_W-1:0] wipe_count;
	logic [CNT_W-1:0] pwr_count;
	wipe_req_t next_req;
	logic next_standby;

	// ********************************************************
	// pin synchronisation and edge detection
	// ********************************************************
	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.clk_en_i(clk_en_i),
		.pin_i({select_n_i, sclk_i, serial_in_line_i}),
		.pin_sync_o(pins_s)
	);

	// synchronised pin names
	assign sel_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign din_s = pins_s[0];

	// delayed copies for edge detection
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			sclk_d <= 1'b1;
			sel_d <= 1'b1;
		end
		else if (clk_en_i)
		begin
			sclk_d <= sclk_s;
			sel_d <= sel_s;
		end
	end

	// edges; clock edges only count while selected
	assign sclk_rise = sclk_s && !sclk_d && !sel_s;
	assign sel_rise = sel_s && !sel_d;
	assign sel_fall = !sel_s && sel_d;

	// ********************************************************
	// frame capture
	// ********************************************************
	// shift msb first, count bits and saturate so long frames never alias
	assign next_shift = sclk_rise ? {shift[30:0], din_s} : shift;
	assign next_bit_cnt = sel_fall ? 6'h00 :
		(sclk_rise && bit_cnt != BIT_CNT_CAP) ? bit_cnt + 6'h01 : bit_cnt;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			shift <= '0;
			bit_cnt <= 6'h00;
		end
		else if (clk_en_i)
		begin
			shift <= next_shift;
			bit_cnt <= next_bit_cnt;
		end
	end

	// views of the captured frame
	assign frame.op_short = shift[7:0];
	assign frame.op_long = shift[31:24];
	assign frame.addr = shift[23:0];
	assign one_byte = (bit_cnt == OPCODE_BITS); // see RULE7 RULE11 RULE15
	assign four_byte = (bit_cnt == ADDR_CMD_BITS); // see RULE3
	assign sector = frame.addr[SECTOR_MSB:SECTOR_LSB]; // see RULE2

	// ********************************************************
	// write-inhibit window after power-on reset
	// ********************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			inhibit_cnt <= INHIBIT_CYCLES;
		else if (clk_en_i && inhibit_cnt != '0)
			inhibit_cnt <= inhibit_cnt - 1'b1;
	end

	assign inhibit = (inhibit_cnt != '0); // see RULE20

	// ********************************************************
	// command decode on select rise
	// ********************************************************
	// write-type commands need standby, no running cycle, no inhibit window
	assign writes_ok = !inhibit && !erase_busy && (pwr == PWR_STANDBY); // see RULE13 RULE20

	// unlock sets the flag that guards both wipes
	assign do_unlock = sel_rise && one_byte && frame.op_short == UNLOCK_OP && writes_ok;

	// sector wipe: 32 bits, flag set, sector not protected
	assign do_block = sel_rise && four_byte && frame.op_long == BLOCK64_OP
		&& writes_ok && write_unlock_flag // see RULE1 RULE3
		&& !sector_protected(protect_level_bits_i, sector); // see RULE5

	// array wipe: 8 bits, flag set, nothing protected
	assign do_array = sel_rise && one_byte && frame.op_short == ARRAY_OP
		&& writes_ok && write_unlock_flag // see RULE6 RULE7
		&& protect_level_bits_i == PROTECT_NONE; // see RULE9

	// sleep only from standby and never while an erase runs
	assign do_sleep = sel_rise && one_byte && frame.op_short == SLEEP_OP
		&& !erase_busy && pwr == PWR_STANDBY; // see RULE11 RULE14

	// wake is the only command heard in deep sleep
	assign do_wake = sel_rise && one_byte && frame.op_short == WAKE_OP
		&& !erase_busy && pwr == PWR_DEEP; // see RULE13 RULE14 RULE15

	assign wipe_go = do_block || do_array;
	assign valid_any = do_unlock || wipe_go || do_sleep || do_wake;

	// frames ending with a nonzero bit count that executed nothing
	assign known_op = (bit_cnt != 6'h00);

	// ********************************************************
	// write-unlock flag
	// ********************************************************
	// cleared as the erase starts, which is before it finishes
	assign next_wel = (write_unlock_flag && !wipe_go) || do_unlock; // see RULE4 RULE8

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			write_unlock_flag <= 1'b0; // see RULE22
		else if (clk_en_i)
			write_unlock_flag <= next_wel;
	end

	// ********************************************************
	// self-timed erase
	// ********************************************************
	assign wipe_count = do_array ? ARRAY_WIPE_CYCLES : BLOCK64_WIPE_CYCLES; // see RULE4 RULE8

	cycle_timer #(
		.CNT_W(CNT_W)
	) u_erase_timer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.clk_en_i(clk_en_i),
		.load_i(wipe_go),
		.count_i(wipe_count),
		.busy_o(erase_busy),
		.done_o(erase_done)
	);

	// request handed to the array; sector field unused for array wipe
	always_comb
	begin
		next_req = wipe_req_o;
		if (do_block)
		begin
			next_req.kind = WIPE_BLOCK64; // see RULE1
			next_req.sector = sector;
			next_req.fill = ERASED_BYTE;
		end
		else if (do_array)
		begin
			next_req.kind = WIPE_ARRAY; // see RULE6
			next_req.sector = 6'h00;
			next_req.fill = ERASED_BYTE;
		end
		else if (erase_done)
		begin
			next_req.kind = WIPE_NONE;
		end
	end

	// ********************************************************
	// power state
	// ********************************************************
	// delay timer shared by sleep entry and wake
	assign pwr_count = do_wake ? CNT_W'(WAKE_CYC) : CNT_W'(SLEEP_ENTRY_CYC);

	cycle_timer #(
		.CNT_W(CNT_W)
	) u_power_timer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.clk_en_i(clk_en_i),
		.load_i(do_sleep || do_wake),
		.count_i(pwr_count),
		.busy_o(pwr_busy),
		.done_o(pwr_done)
	);

	// sleep only through the sleep command, wake only through wake
	always_comb
	begin
		next_pwr = pwr;
		unique case (pwr)
			PWR_STANDBY:
				if (do_sleep)
					next_pwr = PWR_SLEEP_ENTRY; // see RULE10
			PWR_SLEEP_ENTRY:
				if (pwr_done)
					next_pwr = PWR_DEEP; // see RULE12
			PWR_DEEP:
				if (do_wake)
					next_pwr = PWR_WAKE;
			PWR_WAKE:
				if (pwr_done)
					next_pwr = PWR_STANDBY; // see RULE16
		endcase
	end

	// power-on reset always lands in standby
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			pwr <= PWR_STANDBY; // see RULE17 RULE22
		else if (clk_en_i)
			pwr <= next_pwr;
	end

	// deselected, idle and awake
	assign next_standby = sel_s && !wipe_go && (next_pwr == PWR_STANDBY)
		&& !(erase_busy && !erase_done); // see RULE10

	// ********************************************************
	// registered outputs
	// ********************************************************
	// reset holds every output quiet so nothing is answered
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			standby_o <= 1'b1; // see RULE19 RULE22
			deep_power_down_o <= 1'b0;
			write_inhibit_o <= 1'b1;
			wipe_start_o <= 1'b0;
			wipe_req_o <= '{kind: WIPE_NONE, sector: 6'h00, fill: ERASED_BYTE};
			cmd_discard_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			standby_o <= next_standby;
			deep_power_down_o <= (next_pwr == PWR_DEEP);
			write_inhibit_o <= (inhibit_cnt > {{(CNT_W-1){1'b0}}, 1'b1});
			wipe_start_o <= wipe_go;
			wipe_req_o <= next_req;
			cmd_discard_o <= sel_rise && known_op && !valid_any; // see RULE3 RULE15
		end
	end

	// status flags come straight from their flops
	assign write_unlock_flag_o = write_unlock_flag;
	assign cycle_active_flag_o = erase_busy; // see RULE4 RULE8

endmodule // serial_flash_erase_power_control

// ---- sim/spi_host_model.sv ----
// spi host model: select, serial clock and data frames, msb first
// assumes callers run in the sys_clk_i domain; serial clock rests low outside frames
`timescale 1ns/10ps
module spi_host_model (
	// clock
	input wire logic sys_clk_i,
	// spi pins
	output logic select_n_o,
	output logic sclk_o,
	output logic mosi_o
);
	// ****************************************
	// frame driver
	// ****************************************
	// deselected from time zero and through reset; the first frame comes inside the inhibit window
	initial
	begin
		select_n_o = 1'h1;
		sclk_o = 1'h0;
		mosi_o = 1'h0;
	end

	// half period of four system clocks gives the 160 ns serial clock
	task automatic send(input logic [31:0] data, input int nbits);
		repeat (4) @(posedge sys_clk_i);
		select_n_o <= 1'h0;
		for (int i = 0; i < nbits; i++)
		begin
			mosi_o <= data[31 - i];
			repeat (4) @(posedge sys_clk_i);
			sclk_o <= 1'h1;
			repeat (4) @(posedge sys_clk_i);
			sclk_o <= 1'h0;
		end
		repeat (4) @(posedge sys_clk_i);
		select_n_o <= 1'h1;
		mosi_o <= ~mosi_o; // released line never keeps its last bit
		repeat (12) @(posedge sys_clk_i);
	endtask
endmodule // spi_host_model

// ---- sim/serial_flash_erase_power_control_assertions.sv ----
// concurrent checks on the ports of the erase and power-down command block
// assumes clk_en_i stays high while these relations are exercised
`timescale 1ns/10ps
module serial_flash_erase_power_control_assertions
	import flash_cmd_pkg::*;
#(
	parameter logic [CNT_W-1:0] BLOCK64_WIPE_CYCLES = CNT_W'(BLOCK64_WIPE_CYC),
	parameter logic [CNT_W-1:0] ARRAY_WIPE_CYCLES = CNT_W'(ARRAY_WIPE_CYC)
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// configuration and status
	input wire logic [2:0] protect_level_bits_i,
	input wire logic write_unlock_flag_o,
	input wire logic cycle_active_flag_o,
	input wire logic standby_o,
	input wire logic deep_power_down_o,
	input wire logic write_inhibit_o,
	// erase request
	input wire logic wipe_start_o,
	input wire wipe_req_t wipe_req_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic [CNT_W-1:0] run_len;

	// ****************************************
	// helper logic
	// ****************************************
	// length of the current busy stretch
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || !cycle_active_flag_o)
			run_len <= '0;
		else
			run_len <= run_len + 1'h1;
	end

	sequence s_erase_launch;
		cycle_active_flag_o && !standby_o && !write_unlock_flag_o;
	endsequence

	// idle at entry, then deep sleep holds
	sequence s_deep_hold;
		!cycle_active_flag_o ##1 deep_power_down_o [*4];
	endsequence

	// ****************************************
	// assertions
	// ****************************************
	a_start_busy: assert property (wipe_start_o |-> s_erase_launch)
		else $error("erase start without busy flag");
	a_unlock_used: assert property (wipe_start_o |-> $past(write_unlock_flag_o, 2))
		else $error("erase start without unlock flag");
	a_fill_erased: assert property (wipe_req_o.kind != WIPE_NONE |-> wipe_req_o.fill == ERASED_BYTE)
		else $error("erase fill not all ones");
	a_array_guard: assert property (wipe_start_o && wipe_req_o.kind == WIPE_ARRAY |->
		protect_level_bits_i == PROTECT_NONE)
		else $error("array erase with protection set");
	a_inhibit_guard: assert property (write_inhibit_o |-> !wipe_start_o && !write_unlock_flag_o)
		else $error("write accepted in inhibit window");
	a_deep_quiet: assert property (deep_power_down_o |-> !cycle_active_flag_o && !standby_o)
		else $error("activity in deep sleep");
	a_sleep_idle: assert property ($rose(deep_power_down_o) |-> s_deep_hold)
		else $error("deep sleep entered while busy");
	a_erase_length: assert property ($fell(cycle_active_flag_o) |-> run_len ==
		($past(wipe_req_o.kind) == WIPE_ARRAY ? ARRAY_WIPE_CYCLES : BLOCK64_WIPE_CYCLES))
		else $error("erase length wrong");
	a_reset_state: assert property (disable iff (1'h0) rst_i |=>
		standby_o && !deep_power_down_o
		&& !cycle_active_flag_o && !write_unlock_flag_o && write_inhibit_o)
		else $error("reset state wrong");
endmodule // serial_flash_erase_power_control_assertions

bind serial_flash_erase_power_control serial_flash_erase_power_control_assertions #(
	.BLOCK64_WIPE_CYCLES(BLOCK64_WIPE_CYCLES),
	.ARRAY_WIPE_CYCLES(ARRAY_WIPE_CYCLES)
) chk (
	.sys_clk_i(sys_clk_i),
	.rst_i(rst_i),
	.protect_level_bits_i(protect_level_bits_i),
	.write_unlock_flag_o(write_unlock_flag_o),
	.cycle_active_flag_o(cycle_active_flag_o),
	.standby_o(standby_o),
	.deep_power_down_o(deep_power_down_o),
	.write_inhibit_o(write_inhibit_o),
	.wipe_start_o(wipe_start_o),
	.wipe_req_o(wipe_req_o)
);

// ---- sim/tb_serial_flash_erase_power_control.sv ----
// self-checking bench for the erase and power-down command block
// assumes the host model drives the pins; inhibit and erase timers shortened by parameters, power delays kept
`timescale 1ns/10ps
module tb_serial_flash_erase_power_control import flash_cmd_pkg::*; ();
	localparam logic [31:0] INH = 32'h0000_00C8;
	localparam logic [31:0] B64 = 32'h0000_001E;
	localparam logic [31:0] ARR = 32'h0000_00C8;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic [2:0] prot = 3'h0;
	logic sel_n, sclk, mosi, write_unlock_flag, busy, stby, deep, inh, start, disc;
	wipe_req_t req;
	int failures = 0;
	int check_count = 0;
	int disc_cnt = 0;
	int start_cnt = 0;

	always #10 sys_clk = ~sys_clk;
	// count one-cycle pulses where they are settled
	always @(negedge sys_clk)
	begin
		if (disc === 1'h1) disc_cnt++;
		if (start === 1'h1) start_cnt++;
	end

	spi_host_model host (.sys_clk_i(sys_clk), .select_n_o(sel_n), .sclk_o(sclk), .mosi_o(mosi));
	serial_flash_erase_power_control #(
		.INHIBIT_CYCLES(INH), .BLOCK64_WIPE_CYCLES(B64), .ARRAY_WIPE_CYCLES(ARR)
	) uut (
		.sys_clk_i(sys_clk), .rst_i(rst), .clk_en_i(1'h1),
		.select_n_i(sel_n), .sclk_i(sclk), .serial_in_line_i(mosi),
		.protect_level_bits_i(prot), .write_unlock_flag_o(write_unlock_flag),
		.cycle_active_flag_o(busy), .standby_o(stby), .deep_power_down_o(deep),
		.write_inhibit_o(inh), .wipe_start_o(start), .wipe_req_o(req), .cmd_discard_o(disc)
	);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// bounded wait: 0 busy, 1 deep, 2 inhibit, 3 standby
	task automatic wait_for(input int sel, input logic val);
		logic now;
		for (int n = 0; n < 4000; n++)
		begin
			@(negedge sys_clk);
			now = (sel == 0) ? busy : (sel == 1) ? deep : (sel == 2) ? inh : stby;
			if (now === val) return;
		end
		failures++;
		wrap_up();
	endtask

	// one frame, then the count of starts and discards it caused
	task automatic frame(input logic [31:0] data, input int nbits, input int s, input int d);
		int s0, d0;
		s0 = start_cnt;
		d0 = disc_cnt;
		host.send(data, nbits);
		@(negedge sys_clk);
		check(start_cnt - s0, s);
		check(disc_cnt - d0, d);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_power_up();
		check({req.kind, stby, deep, write_unlock_flag, busy, inh}, {WIPE_NONE, 5'h11});
	endtask

	task automatic t_inhibit();
		frame({DEF_UNLOCK_OP, 24'h0}, 8, 0, 1);
		check(write_unlock_flag, 1'h0);
		wait_for(2, 1'h0);
	endtask

	task automatic t_sector();
		frame({DEF_UNLOCK_OP, 24'h0}, 8, 0, 0);
		check(write_unlock_flag, 1'h1);
		frame({DEF_BLOCK64_OP, 24'hC5ABCD}, 32, 1, 0);
		check({req.kind, req.sector, req.fill, write_unlock_flag, busy}, {WIPE_BLOCK64, 6'h05, ERASED_BYTE, 2'h1});
		wait_for(0, 1'h0);
		// request kind and standby follow one cycle after busy drops
		@(negedge sys_clk);
		check({req.kind, stby}, {WIPE_NONE, 1'h1});
	endtask

	task automatic t_refusals();
		frame({DEF_BLOCK64_OP, 24'h010000}, 32, 0, 1);
		frame({DEF_UNLOCK_OP, 24'h0}, 8, 0, 0);
		frame({DEF_BLOCK64_OP, 24'h010000}, 31, 0, 1);
		frame({DEF_ARRAY_OP, 24'h0}, 9, 0, 1);
		@(posedge sys_clk) prot <= 3'h1;
		frame({DEF_BLOCK64_OP, 24'h3F0000}, 32, 0, 1);
		frame({DEF_ARRAY_OP, 24'h0}, 8, 0, 1);
		check(write_unlock_flag, 1'h1);
		@(posedge sys_clk) prot <= 3'h0;
		frame({DEF_ARRAY_OP, 24'h0}, 8, 1, 0);
		check({req.kind, req.fill}, {WIPE_ARRAY, ERASED_BYTE});
		frame({DEF_SLEEP_OP, 24'h0}, 8, 0, 1);
		check({busy, deep}, 2'h2);
		wait_for(0, 1'h0);
	endtask

	task automatic t_sleep();
		frame({DEF_SLEEP_OP, 24'h0}, 9, 0, 1);
		frame({DEF_SLEEP_OP, 24'h0}, 8, 0, 0);
		check(deep, 1'h0);
		wait_for(1, 1'h1);
		frame({DEF_UNLOCK_OP, 24'h0}, 8, 0, 1);
		check(write_unlock_flag, 1'h0);
		frame({DEF_WAKE_OP, 24'h0}, 9, 0, 1);
		check(deep, 1'h1);
		frame({DEF_WAKE_OP, 24'h0}, 8, 0, 0);
		check({deep, stby}, 2'h0);
		wait_for(3, 1'h1);
	endtask

	// power loss in deep sleep comes back in standby
	task automatic t_power_loss();
		frame({DEF_SLEEP_OP, 24'h0}, 8, 0, 0);
		wait_for(1, 1'h1);
		@(posedge sys_clk) rst <= 1'h1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'h0;
		@(negedge sys_clk);
		t_power_up();
		wait_for(2, 1'h0);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		t_power_up();
		@(posedge sys_clk) rst <= 1'h0;
		@(negedge sys_clk);
		t_power_up();
		t_inhibit();
		t_sector();
		t_refusals();
		t_sleep();
		t_power_loss();
		wrap_up();
	end
endmodule // tb_serial_flash_erase_power_control
